// File: common/usb_fn_pkg.sv
/*
 Shared constants and carrier types for the USB function error handling
 and input buffer control block.
 Assumes a 32-bit APB bus whose byte address is four times a register index.
*/
package usb_fn_pkg;

	// ---------------------------------------------------------------
	// Register map (indices; byte address is index times four)
	// ---------------------------------------------------------------
	localparam int ADDR_W = 18;
	localparam logic [15:0] IDX_IRQ_STATUS = 16'hff80;
	localparam logic [15:0] IDX_IRQ_MASK = 16'hff81;
	localparam logic [15:0] IDX_STALL_REQ = 16'hff82;
	localparam logic [15:0] IDX_EP_STATE = 16'hff83;
	localparam logic [15:0] IDX_ALT_CFG = 16'hff84;
	localparam logic [15:0] IDX_BUF_CTRL = 16'hff8b;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_STALL_REQ = {IDX_STALL_REQ, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_EP_STATE = {IDX_EP_STATE, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_ALT_CFG = {IDX_ALT_CFG, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_BUF_CTRL = {IDX_BUF_CTRL, 2'b00};

	// ---------------------------------------------------------------
	// Field positions and values after reset
	// ---------------------------------------------------------------
	localparam int BIT_FLOAT_GUARD_OFF = 0;
	localparam int BIT_BUFFER_ON = 1;
	localparam int BIT_CTRL_STALL_REQ = 0;
	localparam int ALT_VALID0_LSB = 0;
	localparam int ALT_VALID1_LSB = 4;
	localparam int BIT_ALT_SEL = 7;
	localparam logic [1:0] BUF_CTRL_RST = 2'h0;
	localparam logic [7:0] ALT_CFG_RST = 8'h77;
	localparam int NUM_EP = 3;
	localparam int NUM_IRQ = 5;
	localparam int IRQ_STALL = 0;
	localparam int IRQ_HALT = 1;
	localparam int IRQ_DISCARD = 2;
	localparam int IRQ_RETX = 3;
	localparam int IRQ_LINE = 4;
	// Endpoints that accept each token direction: 0 both, 1 OUT, 2 IN
	localparam logic [NUM_EP-1:0] EP_OUT_OK = 3'h3;
	localparam logic [NUM_EP-1:0] EP_IN_OK = 3'h5;
	localparam logic [NUM_EP-1:0] EP_SETUP_OK = 3'h1;

	// ---------------------------------------------------------------
	// Enumerations and carriers
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {TOK_OUT = 2'h0, TOK_IN = 2'h1, TOK_SETUP = 2'h2} token_e;
	typedef enum logic [1:0] {ST_SETUP = 2'h0, ST_DATA = 2'h1, ST_STATUS = 2'h2,
		ST_BULK = 2'h3} stage_e;
	typedef enum logic [1:0] {HS_NONE = 2'h0, HS_ACK = 2'h1, HS_STALL = 2'h2} hs_e;
	typedef enum logic [1:0] {APB_IDLE = 2'b01, APB_ACCESS = 2'b10} apb_st_e;

	typedef struct packed {
		logic valid;
		token_e tok;
		stage_e stage;
		logic [1:0] ep;
		logic tok_crc_err;
		logic tok_stuff_err;
		logic data_timeout;
		logic data_pid_chk_err;
		logic data_non_data_pid;
		logic data_crc_err;
		logic data_stuff_err;
		logic data_pid_mismatch;
		logic overrun;
		logic over_maxpkt;
		logic hs_pid_chk_err;
		logic hs_not_ack;
		logic hs_timeout;
		logic stage_change;
	} usb_evt_s;

	typedef struct packed {
		logic valid;
		hs_e hs;
		logic discard;
		logic retransmit;
		logic [1:0] ep;
	} usb_resp_s;

	typedef struct packed {
		logic bus_reset;
		logic suspend;
		logic resume;
	} line_evt_s;

endpackage

// File: core/usb_resp_decode.sv
/*
 Decides the handshake, discard and retransmit answer for one finished
 transaction, and which stall or halt flags it raises. Purely combinational.
 Assumes the protocol engine reports each transaction once, with all
 error classes already classified.
*/
`timescale 1ns/10ps
module usb_resp_decode
	import usb_fn_pkg::*;
(
	input usb_fn_pkg::usb_evt_s evt,
	input logic stall_req,
	input logic [usb_fn_pkg::NUM_EP-1:0] ep_halt,
	input logic [usb_fn_pkg::NUM_EP-1:0] ep_valid,
	output usb_fn_pkg::usb_resp_s resp,
	output logic set_stall,
	output logic [usb_fn_pkg::NUM_EP-1:0] set_halt
);

	logic [NUM_EP-1:0] dir_ok;
	logic ep_stalled;

	// ---------------------------------------------------------------
	// Endpoint checks
	// ---------------------------------------------------------------
	always_comb
	begin
		unique case (evt.tok)
			TOK_OUT: dir_ok = EP_OUT_OK;
			TOK_IN: dir_ok = EP_IN_OK;
			TOK_SETUP: dir_ok = EP_SETUP_OK;
			default: dir_ok = '0;
		endcase
	end

	// Control endpoint stalls on request; bulk endpoints stall when halted
	assign ep_stalled = (evt.stage == ST_BULK) ? ep_halt[evt.ep] :
		(stall_req && evt.ep == 2'h0 && evt.stage != ST_SETUP);

	// ---------------------------------------------------------------
	// Response priority: token, data timeout and PID, stall, data CRC and stuffing, overrun
	// ---------------------------------------------------------------
	always_comb
	begin
		resp = '0;
		resp.valid = evt.valid;
		resp.ep = evt.ep;
		set_stall = 1'b0;
		set_halt = '0;
		if (evt.ep == 2'h3 || !ep_valid[evt.ep] || !dir_ok[evt.ep]
			|| evt.tok_crc_err || evt.tok_stuff_err)
		begin
			resp.hs = HS_NONE;
		end
		else if (evt.tok == TOK_IN)
		begin
			if (evt.hs_pid_chk_err || evt.hs_not_ack || evt.hs_timeout)
			begin
				resp.retransmit = 1'b1;
			end
			else if (ep_stalled)
			begin
				resp.hs = HS_STALL;
			end
		end
		else if (evt.data_timeout || evt.data_pid_chk_err || evt.data_non_data_pid)
		begin
			resp.hs = HS_NONE;
		end
		else if (evt.tok == TOK_OUT && evt.stage_change)
		begin
			resp.hs = HS_ACK;
		end
		else if (evt.tok == TOK_OUT && ep_stalled)
		begin
			resp.hs = HS_STALL;
			resp.discard = 1'b1;
		end
		else if (evt.data_crc_err || evt.data_stuff_err)
		begin
			resp.hs = HS_NONE;
			resp.discard = 1'b1;
		end
		else if (evt.tok == TOK_OUT && evt.data_pid_mismatch)
		begin
			resp.hs = HS_ACK;
			resp.discard = 1'b1;
		end
		else if (evt.overrun)
		begin
			resp.discard = 1'b1;
			if (evt.tok == TOK_OUT)
			begin
				unique case (evt.stage)
					ST_DATA: set_stall = 1'b1;
					ST_STATUS:
					begin
						resp.hs = evt.over_maxpkt ? HS_NONE : HS_ACK;
						set_stall = evt.over_maxpkt;
					end
					ST_BULK: set_halt[evt.ep] = 1'b1;
					default: resp.hs = HS_NONE;
				endcase
			end
		end
		else
		begin
			resp.hs = HS_ACK;
		end
		if (!evt.valid)
		begin
			set_stall = 1'b0;
			set_halt = '0;
		end
	end

endmodule

// File: core/usb_function_error_and_buffer_ctl.sv
/*
 USB function error handling and input buffer control: APB register file,
 handshake decisions per transaction, stall and halt flags, line event
 filtering with floating protection, and a level interrupt.
 Assumes all inputs are synchronous to pclk and that the protocol engine
 pulses evt.valid once per finished transaction.
 Every register is one byte in lane 0 of the APB data; the byte address
 is four times the register index. Read data is captured in the setup
 cycle, so each access completes with no wait state.
*/
`timescale 1ns/10ps
module usb_function_error_and_buffer_ctl
	import usb_fn_pkg::*;
(
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [usb_fn_pkg::ADDR_W-1:0] paddr,
	input logic [31:0] pwdata,
	input logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input usb_fn_pkg::usb_evt_s evt,
	input usb_fn_pkg::line_evt_s line_raw,
	input logic vbus,
	output usb_fn_pkg::usb_resp_s resp,
	output usb_fn_pkg::line_evt_s line_evt,
	output logic buffer_on,
	output logic float_guard_on,
	output logic irq
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	// All flops of the block live in one record, so reset and update
	// cannot miss a field; the output copies sit at the end
	typedef struct packed {
		apb_st_e apb_st;
		logic pready;
		logic pslverr;
		logic [7:0] prdata;
		logic [1:0] buf_ctrl;
		logic stall_req;
		logic [NUM_EP-1:0] ep_halt;
		logic [7:0] alt_cfg;
		logic [NUM_IRQ-1:0] irq_status;
		logic [NUM_IRQ-1:0] irq_mask;
		logic irq;
		usb_resp_s resp;
		line_evt_s line_evt;
		logic buffer_on;
		logic float_guard_on;
	} state_s;

	state_s state_reg;
	state_s state_next;

	// Combinational helpers between the decoders and the next-state logic
	usb_resp_s dec_resp;
	logic dec_set_stall;
	logic [NUM_EP-1:0] dec_set_halt;
	logic [NUM_EP-1:0] ep_valid;
	logic line_pass;
	line_evt_s line_gated;
	logic addr_hit;
	logic [7:0] rd_byte;
	logic wr_take;
	logic [7:0] wbyte;
	logic [NUM_IRQ-1:0] irq_events;

	// ---------------------------------------------------------------
	// Transaction response decision
	// ---------------------------------------------------------------
	// Endpoint set depends on the alternate setting now selected
	// Bit 7 picks which of the two three-bit fields is in force
	assign ep_valid = state_reg.alt_cfg[BIT_ALT_SEL] ?
		state_reg.alt_cfg[ALT_VALID1_LSB +: NUM_EP] :
		state_reg.alt_cfg[ALT_VALID0_LSB +: NUM_EP];

	// The decision is purely combinational; the answer is registered in
	// the next-state logic, so the protocol engine sees it one edge later
	usb_resp_decode u_decode (
		.evt(evt),
		.stall_req(state_reg.stall_req),
		.ep_halt(state_reg.ep_halt),
		.ep_valid(ep_valid),
		.resp(dec_resp),
		.set_stall(dec_set_stall),
		.set_halt(dec_set_halt)
	);

	// ---------------------------------------------------------------
	// Line event filter
	// ---------------------------------------------------------------
	// A floating cable gives random line states; with the guard on, only
	// a present VBUS lets reset, suspend and resume through. With the guard
	// off the events pass whenever the buffer is on, and software must judge them from VBUS itself.
	// Gating sits before the output flop, so line_evt lags one cycle.
	assign line_pass = state_reg.buf_ctrl[BIT_BUFFER_ON]
		&& (state_reg.buf_ctrl[BIT_FLOAT_GUARD_OFF] || vbus);
	assign line_gated = line_pass ? line_raw : '0;

	// ---------------------------------------------------------------
	// Register read mux and address decode
	// ---------------------------------------------------------------
	// Any address outside the map clears addr_hit, which turns the access
	// into an error with zero read data and no write
	always_comb
	begin
		addr_hit = 1'b1;
		rd_byte = 8'h00;
		unique case (paddr)
			ADDR_BUF_CTRL: rd_byte = {6'h00, state_reg.buf_ctrl};
			ADDR_IRQ_STATUS: rd_byte = {3'h0, state_reg.irq_status};
			ADDR_IRQ_MASK: rd_byte = {3'h0, state_reg.irq_mask};
			ADDR_STALL_REQ: rd_byte = {7'h00, state_reg.stall_req};
			ADDR_EP_STATE: rd_byte = {5'h00, state_reg.ep_halt};
			ADDR_ALT_CFG: rd_byte = state_reg.alt_cfg;
			default: addr_hit = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// Write qualification
	// ---------------------------------------------------------------
	// Write lands only at the completing access edge and only on lane 0;
	// upper lanes are not part of the byte-wide registers
	assign wr_take = psel && penable && state_reg.pready && pwrite && pstrb[0]
		&& !state_reg.pslverr;
	assign wbyte = pwdata[7:0];

	// ---------------------------------------------------------------
	// Interrupt events
	// ---------------------------------------------------------------
	// Events that raise sticky interrupt status; a line event keeps setting
	// its bit for as long as the gated level stays high
	assign irq_events[IRQ_STALL] = dec_set_stall;
	assign irq_events[IRQ_HALT] = |dec_set_halt;
	assign irq_events[IRQ_DISCARD] = dec_resp.valid && dec_resp.discard;
	assign irq_events[IRQ_RETX] = dec_resp.valid && dec_resp.retransmit;
	assign irq_events[IRQ_LINE] = |line_gated;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb
	begin
		// Hold everything by default; the one-cycle strobes fall back to zero
		state_next = state_reg;
		state_next.pready = 1'b0;
		state_next.resp.valid = 1'b0;

		// APB slave: one access cycle, answer prepared in setup. A setup that
		// follows a completion at once is seen because the access state
		// always returns to idle after one cycle
		unique case (state_reg.apb_st)
			APB_IDLE:
			begin
				if (psel && !penable)
				begin
					state_next.apb_st = APB_ACCESS;
					state_next.pready = 1'b1;
					state_next.pslverr = !addr_hit;
					state_next.prdata = addr_hit ? rd_byte : 8'h00;
				end
			end
			APB_ACCESS:
			begin
				state_next.apb_st = APB_IDLE;
				state_next.pslverr = 1'b0;
				state_next.prdata = 8'h00;
			end
			default:
			begin
				state_next.apb_st = APB_IDLE;
			end
		endcase

		// Software writes first, so a hardware set below wins
		if (wr_take)
		begin
			unique case (paddr)
				ADDR_BUF_CTRL:
				begin
					state_next.buf_ctrl = wbyte[1:0];
				end
				ADDR_IRQ_STATUS:
				begin
					state_next.irq_status = state_reg.irq_status & ~wbyte[NUM_IRQ-1:0];
				end
				ADDR_IRQ_MASK:
				begin
					state_next.irq_mask = wbyte[NUM_IRQ-1:0];
				end
				ADDR_STALL_REQ:
				begin
					state_next.stall_req = wbyte[BIT_CTRL_STALL_REQ];
				end
				ADDR_EP_STATE:
				begin
					state_next.ep_halt = wbyte[NUM_EP-1:0];
				end
				ADDR_ALT_CFG:
				begin
					state_next.alt_cfg = wbyte;
				end
				default:
				begin
					// Unmapped: refused by pslverr, so nothing changes
					state_next.alt_cfg = state_reg.alt_cfg;
				end
			endcase
		end

		// Hardware sets from the transaction decision. They are applied on
		// top of the software write, so a clear in the same cycle loses
		if (dec_set_stall)
		begin
			state_next.stall_req = 1'b1;
		end
		state_next.ep_halt = state_next.ep_halt | dec_set_halt;
		state_next.irq_status = state_next.irq_status | irq_events;

		// Registered answer to the protocol engine
		if (evt.valid)
		begin
			state_next.resp = dec_resp;
		end

		// Registered outputs, taken from the next values so that the pins
		// change on the same edge as the register bits behind them
		state_next.line_evt = line_gated;
		state_next.buffer_on = state_next.buf_ctrl[BIT_BUFFER_ON];
		state_next.float_guard_on = !state_next.buf_ctrl[BIT_FLOAT_GUARD_OFF];
		state_next.irq = |(state_next.irq_status & state_next.irq_mask);
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	// Asynchronous reset to the package values; only constants are used here
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg.apb_st <= APB_IDLE;
			state_reg.pready <= 1'b0;
			state_reg.pslverr <= 1'b0;
			state_reg.prdata <= 8'h00;
			state_reg.buf_ctrl <= BUF_CTRL_RST;
			state_reg.stall_req <= 1'b0;
			state_reg.ep_halt <= '0;
			state_reg.alt_cfg <= ALT_CFG_RST;
			state_reg.irq_status <= '0;
			state_reg.irq_mask <= '0;
			state_reg.irq <= 1'b0;
			state_reg.resp <= '0;
			state_reg.line_evt <= '0;
			// Pins start from the reset byte, so the guard is on until written
			state_reg.buffer_on <= BUF_CTRL_RST[BIT_BUFFER_ON];
			state_reg.float_guard_on <= !BUF_CTRL_RST[BIT_FLOAT_GUARD_OFF];
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ---------------------------------------------------------------
	// Outputs, all straight from the state register
	// ---------------------------------------------------------------
	// Upper read lanes are tied to zero: every register is one byte
	assign prdata = {24'h000000, state_reg.prdata};
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign resp = state_reg.resp;
	assign line_evt = state_reg.line_evt;
	assign buffer_on = state_reg.buffer_on;
	assign float_guard_on = state_reg.float_guard_on;
	assign irq = state_reg.irq;

endmodule

// File: dv/usb_fn_assertions.sv
/*
 Checker for the USB function error and buffer control block.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
module usb_fn_assertions
	import usb_fn_pkg::*;
(
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [usb_fn_pkg::ADDR_W-1:0] paddr,
	input logic [31:0] pwdata,
	input logic [3:0] pstrb,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	input usb_fn_pkg::usb_evt_s evt,
	input usb_fn_pkg::line_evt_s line_raw,
	input logic vbus,
	input usb_fn_pkg::usb_resp_s resp,
	input usb_fn_pkg::line_evt_s line_evt,
	input logic buffer_on,
	input logic float_guard_on
);
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// No token or data fault that outranks the case under test
	wire clean = (evt[13:6] == 8'h0);
	wire setup_c = psel && !penable;
	wire gate = buffer_on && (!float_guard_on || vbus);
	// Software may drop endpoint 0 from the alternate setting; follow the
	// completed writes so that the checks below judge admitted traffic only
	logic [7:0] alt_seen;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			alt_seen <= ALT_CFG_RST;
		else if (psel && penable && pready && !pslverr && pwrite && pstrb[0]
			&& paddr == ADDR_ALT_CFG)
			alt_seen <= pwdata[7:0];
	end
	wire ep0_ok = alt_seen[BIT_ALT_SEL] ? alt_seen[ALT_VALID1_LSB] : alt_seen[ALT_VALID0_LSB];
	// Both output flops take the written byte at the completing edge
	property p_buf_wr;
		setup_c ##1 (pready && pwrite && pstrb[0] && paddr == ADDR_BUF_CTRL)
			|=> (buffer_on == $past(pwdata[1]) && float_guard_on == !$past(pwdata[0]));
	endproperty
	a_resp_follows: assert property (evt.valid |=> resp.valid && resp.ep == $past(evt.ep))
		else $error("response pulse missing");
	a_token_silent: assert property (evt.valid && evt[13:12] != 2'h0 |=>
		resp.hs == HS_NONE && !resp.discard) else $error("bad token answered");
	a_ep3_silent: assert property (evt.valid && evt.ep == 2'h3 |=> resp.hs == HS_NONE)
		else $error("unsupported endpoint answered");
	a_in_retx: assert property (evt.valid && ep0_ok && clean && evt.tok == TOK_IN
		&& evt.ep == 2'h0 && evt[3:1] != 3'h0 |=> resp.retransmit) else $error("no retransmit");
	a_setup_ovr: assert property (evt.valid && ep0_ok && clean && evt.tok == TOK_SETUP
		&& evt.overrun && evt.ep == 2'h0 |=> resp.hs == HS_NONE && resp.discard)
		else $error("setup overrun");
	a_data_ovr: assert property (evt.valid && ep0_ok && clean && evt.tok == TOK_OUT
		&& evt.ep == 2'h0 && evt.stage == ST_DATA && evt.overrun && !evt.stage_change
		|=> resp.discard && resp.hs != HS_ACK) else $error("data overrun acked");
	a_line_gate: assert property (1'b1 |=> line_evt == ($past(line_raw) & {3{$past(gate)}}))
		else $error("line event not gated");
	a_pready_pulse: assert property (setup_c |=> pready ##1 !pready)
		else $error("pready not one cycle");
	a_buf_write: assert property (p_buf_wr)
		else $error("buffer control outputs wrong");
	a_buf_read: assert property (setup_c && !pwrite && paddr == ADDR_BUF_CTRL |=>
		prdata[31:2] == 30'h0 && !pslverr) else $error("unused bits not zero");
	a_unmapped: assert property (setup_c && paddr == 18'h0 |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	c_stall: cover property (resp.valid && resp.hs == HS_STALL);
	c_retx: cover property (resp.valid && resp.retransmit);
	c_line: cover property (line_evt != 3'h0);
endmodule

bind usb_function_error_and_buffer_ctl usb_fn_assertions u_usb_fn_assertions (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .evt,
	.line_raw, .vbus, .resp, .line_evt, .buffer_on, .float_guard_on);

// File: dv/usb_host_model.sv
/*
 Host side: issues one finished transaction at a time on evt.
 Assumes the caller supplies error classes; gap adds idle cycles.
*/
`timescale 1ns/10ps
module usb_host_model
	import usb_fn_pkg::*;
(
	input logic pclk,
	output usb_fn_pkg::usb_evt_s evt
);
	// ---------------------------------------------------------------
	// Transaction driver
	// ---------------------------------------------------------------
	initial evt = '0;
	// Idle fields show inverted junk so a stale value never looks valid
	task automatic send(input usb_evt_s e, input int gap);
		repeat (gap) @(posedge pclk);
		@(posedge pclk);
		evt <= e;
		@(posedge pclk);
		evt <= {1'b0, ~e[19:0]};
	endtask
endmodule

// File: dv/usb_function_error_and_buffer_ctl_tb.sv
/*
 Self-checking bench: APB register traffic and host transactions.
 Assumes the host model and the bound checker are compiled first.
*/
`timescale 1ns/10ps
module usb_function_error_and_buffer_ctl_tb;
	import usb_fn_pkg::*;
	localparam logic [13:0] F_TOK = 14'h2000, F_TMO = 14'h0800, F_CRC = 14'h0100;
	localparam logic [13:0] F_PID = 14'h0040, F_OVR = 14'h0020, F_MAX = 14'h0010;
	localparam logic [13:0] F_HST = 14'h0002, F_STG = 14'h0001;
	localparam logic [13:0] F_TST = 14'h1000, F_PCK = 14'h0400, F_NDP = 14'h0200;
	localparam logic [13:0] F_DST = 14'h0080, F_HPC = 14'h0008, F_HNA = 14'h0004;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic perr;
	usb_evt_s evt;
	line_evt_s line_raw = '0;
	logic vbus = 1'b0;
	usb_resp_s resp;
	line_evt_s line_evt;
	logic buffer_on;
	logic float_guard_on;
	logic irq;
	int miscompares = 0;
	int n_tests = 0;

	// ---------------------------------------------------------------
	// Clock, design and host
	// ---------------------------------------------------------------
	always #4 pclk = ~pclk;
	usb_function_error_and_buffer_ctl u_usb_function_error_and_buffer_ctl (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.evt, .line_raw, .vbus, .resp, .line_evt, .buffer_on, .float_guard_on, .irq);
	usb_host_model u_usb_host_model (.pclk, .evt);

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Zero wait states are not assumed; the loop bound catches a hang
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 64);
		if (n >= 64)
		begin
			miscompares++;
			close_out();
		end
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h0);
		chk(prdata, {24'h0, e});
	endtask
	// Send one transaction, then judge the answer one edge later
	task automatic ev(input token_e tk, input stage_e sg, input logic [1:0] ep,
		input logic [13:0] f, input hs_e h, input logic d, input logic rt);
		u_usb_host_model.send({1'b1, tk, sg, ep, f}, int'(ep));
		@(posedge pclk);
		chk({25'h0, resp}, {25'h0, 1'b1, h, d, rt, ep});
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_regs();
		rd(ADDR_BUF_CTRL, 8'h00);
		rd(ADDR_ALT_CFG, 8'h77);
		chk({31'h0, float_guard_on}, 32'h1);
		apb(1'b1, ADDR_BUF_CTRL, 8'hff);
		rd(ADDR_BUF_CTRL, 8'h03);
		chk({30'h0, buffer_on, float_guard_on}, 32'h2);
		pstrb <= 4'h0;
		apb(1'b1, ADDR_BUF_CTRL, 8'h00);
		pstrb <= 4'hf;
		rd(ADDR_BUF_CTRL, 8'h03);
		rd(18'h0, 8'h00);
		chk({31'h0, perr}, 32'h1);
		apb(1'b1, ADDR_BUF_CTRL, 8'h00);
		$display("t_regs done");
	endtask
	task automatic t_line();
		apb(1'b1, ADDR_BUF_CTRL, 8'h02);
		line_raw <= 3'h7;
		settle(2);
		chk({29'h0, line_evt}, 32'h0);
		vbus <= 1'b1;
		settle(2);
		chk({29'h0, line_evt}, 32'h7);
		line_raw <= 3'h0;
		vbus <= 1'b0;
		apb(1'b1, ADDR_BUF_CTRL, 8'h03);
		line_raw <= 3'h5;
		settle(2);
		chk({29'h0, line_evt}, 32'h5);
		line_raw <= 3'h0;
		apb(1'b1, ADDR_BUF_CTRL, 8'h00);
		$display("t_line done");
	endtask
	task automatic t_errs();
		ev(TOK_OUT, ST_BULK, 2'h0, F_TOK, HS_NONE, 1'b0, 1'b0);
		ev(TOK_IN, ST_BULK, 2'h3, 14'h0, HS_NONE, 1'b0, 1'b0);
		ev(TOK_SETUP, ST_SETUP, 2'h1, 14'h0, HS_NONE, 1'b0, 1'b0);
		ev(TOK_OUT, ST_BULK, 2'h2, 14'h0, HS_NONE, 1'b0, 1'b0);
		ev(TOK_OUT, ST_BULK, 2'h1, F_TMO, HS_NONE, 1'b0, 1'b0);
		ev(TOK_IN, ST_BULK, 2'h0, F_TST, HS_NONE, 1'b0, 1'b0);
		ev(TOK_OUT, ST_BULK, 2'h1, F_PCK, HS_NONE, 1'b0, 1'b0);
		ev(TOK_SETUP, ST_SETUP, 2'h0, F_NDP, HS_NONE, 1'b0, 1'b0);
		ev(TOK_OUT, ST_BULK, 2'h1, F_DST, HS_NONE, 1'b1, 1'b0);
		ev(TOK_SETUP, ST_SETUP, 2'h0, F_CRC, HS_NONE, 1'b1, 1'b0);
		ev(TOK_OUT, ST_BULK, 2'h1, F_PID, HS_ACK, 1'b1, 1'b0);
		ev(TOK_SETUP, ST_SETUP, 2'h0, F_OVR, HS_NONE, 1'b1, 1'b0);
		ev(TOK_IN, ST_BULK, 2'h2, F_HST, HS_NONE, 1'b0, 1'b1);
		ev(TOK_IN, ST_DATA, 2'h0, F_HPC, HS_NONE, 1'b0, 1'b1);
		ev(TOK_IN, ST_BULK, 2'h2, F_HNA, HS_NONE, 1'b0, 1'b1);
		ev(TOK_OUT, ST_STATUS, 2'h0, F_STG, HS_ACK, 1'b0, 1'b0);
		apb(1'b1, ADDR_ALT_CFG, 8'h97);
		ev(TOK_OUT, ST_BULK, 2'h1, 14'h0, HS_NONE, 1'b0, 1'b0);
		apb(1'b1, ADDR_ALT_CFG, 8'h77);
		ev(TOK_OUT, ST_BULK, 2'h1, 14'h0, HS_ACK, 1'b0, 1'b0);
		$display("t_errs done");
	endtask
	task automatic t_stall();
		apb(1'b1, ADDR_IRQ_STATUS, 8'h1f);
		apb(1'b1, ADDR_IRQ_MASK, 8'h01);
		ev(TOK_OUT, ST_DATA, 2'h0, F_OVR, HS_NONE, 1'b1, 1'b0);
		settle(1);
		chk({31'h0, irq}, 32'h1);
		rd(ADDR_STALL_REQ, 8'h01);
		ev(TOK_OUT, ST_DATA, 2'h0, 14'h0, HS_STALL, 1'b1, 1'b0);
		ev(TOK_IN, ST_STATUS, 2'h0, 14'h0, HS_STALL, 1'b0, 1'b0);
		apb(1'b1, ADDR_IRQ_MASK, 8'h00);
		settle(1);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, ADDR_STALL_REQ, 8'h00);
		apb(1'b1, ADDR_IRQ_STATUS, 8'h01);
		apb(1'b1, ADDR_IRQ_MASK, 8'h01);
		settle(1);
		chk({31'h0, irq}, 32'h0);
		ev(TOK_OUT, ST_STATUS, 2'h0, F_OVR, HS_ACK, 1'b1, 1'b0);
		ev(TOK_OUT, ST_STATUS, 2'h0, F_OVR | F_MAX, HS_NONE, 1'b1, 1'b0);
		rd(ADDR_STALL_REQ, 8'h01);
		apb(1'b1, ADDR_STALL_REQ, 8'h00);
		$display("t_stall done");
	endtask
	task automatic t_bulk();
		for (int i = 0; i < 2; i++)
		begin
			ev(TOK_OUT, ST_BULK, i[1:0], F_OVR, HS_NONE, 1'b1, 1'b0);
			ev(TOK_OUT, ST_BULK, i[1:0], 14'h0, HS_STALL, 1'b1, 1'b0);
		end
		rd(ADDR_EP_STATE, 8'h03);
		$display("t_bulk done");
	endtask

	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_line();
		t_errs();
		t_stall();
		t_bulk();
		close_out();
	end
endmodule
